// *** verilog/gdfc_pkg.sv ***
// Package for the gate drive fault control block: widths, field positions and timing figures.
// Assumes a single 50 MHz core clock domain.
`default_nettype none
package gdfc_pkg;
    // Core clock period and dead-time step, in picoseconds.
    localparam int unsigned CLK_PERIOD_PS    = 20000;
    localparam int unsigned DEAD_STEP_PS     = 4000;
    // Width of each dead-time code field.
    localparam int unsigned DEAD_CODE_W      = 6;
    // Width of the blanking select field, held at bits 1:0 of the overcurrent configuration.
    localparam int unsigned BLANK_SEL_W      = 2;
    localparam int unsigned BLANK_SEL_LSB    = 0;
    // Blanking counter width and the cycle count per blanking select step.
    localparam int unsigned BLANK_CNT_W      = 8;
    localparam logic [7:0]  BLANK_STEP_CYC   = 8'h05;
    // Synchroniser depth for analog comparator outputs.
    localparam int unsigned SYNC_STAGES      = 2;
    // Lowest and highest switching frequency of the PWM timebase, in kHz.
    localparam int unsigned FSW_MIN_KHZ      = 100;
    localparam int unsigned FSW_MAX_KHZ      = 1600;
    // Dead-time state machine states.
    typedef enum logic [1:0] {
        GDFC_ST_BOTH_OFF,
        GDFC_ST_HIGH_ON,
        GDFC_ST_LOW_ON
    } gdfc_drive_e;
endpackage
`default_nettype wire

// *** verilog/gdfc_sync.sv ***
// Two-stage synchroniser for one asynchronous comparator level.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps
`default_nettype none
module gdfc_sync #(
    parameter int unsigned STAGES = 2
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [STAGES-1:0] chain_r;

    // Shift the level through the chain; only the last stage is read outside.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_r[STAGES-1];
endmodule
`default_nettype wire

// *** verilog/gdfc_top.sv ***
// Gate drive fault control: dead time, force-low gating, fault flags, overcurrent blanking.
// Assumes PWM edges from the period timer arrive synchronous to clock; comparators are async.
`timescale 1ns/1ps
`default_nettype none
module gdfc_top #(
    parameter int unsigned DEAD_W  = gdfc_pkg::DEAD_CODE_W,
    parameter int unsigned VSET_W  = 8
) (
    input  wire logic                            clock,
    input  wire logic                            rst,
    input  wire logic                            pwm_in,
    input  wire logic [DEAD_W-1:0]               dead_time_setting_high,
    input  wire logic [DEAD_W-1:0]               dead_time_setting_low,
    input  wire logic                            high_side_delay_bypass,
    input  wire logic                            low_side_delay_bypass,
    input  wire logic                            whole_driver_disable,
    input  wire logic                            high_side_disable,
    input  wire logic                            low_side_disable,
    input  wire logic                            input_uv_compare_enable,
    input  wire logic                            input_uv_cmp,
    input  wire logic [7:0]                      overcurrent_config,
    input  wire logic                            overcurrent_compare_enable,
    input  wire logic                            overcurrent_cmp,
    input  wire logic                            out_undervolt_compare_enable,
    input  wire logic                            out_overvolt_compare_enable,
    input  wire logic                            out_undervolt_cmp,
    input  wire logic                            out_overvolt_cmp,
    input  wire logic                            undervolt_trip_gate,
    input  wire logic                            overvolt_trip_gate,
    input  wire logic                            out_undervolt_flag_clear,
    input  wire logic                            out_overvolt_flag_clear,
    input  wire logic                            overcurrent_flag_clear,
    input  wire logic [VSET_W-1:0]               vout_coarse_set,
    input  wire logic [VSET_W-1:0]               vout_fine_set,
    output logic                                 high_gate_drive,
    output logic                                 low_gate_drive,
    output logic                                 input_uv_flag,
    output logic                                 out_undervolt_flag,
    output logic                                 out_overvolt_flag,
    output logic                                 overcurrent_flag,
    output logic [2*VSET_W-1:0]                  vout_target
);
    // Dead-time cycles per code step, rounded up to at least one cycle.
    localparam int unsigned DEAD_STEP_CYC =
        (gdfc_pkg::DEAD_STEP_PS + gdfc_pkg::CLK_PERIOD_PS - 1) / gdfc_pkg::CLK_PERIOD_PS;
    localparam int unsigned DCNT_W = DEAD_W + 4;

    logic                      uv_in_s;
    logic                      uvo_s;
    logic                      ovo_s;
    logic                      oc_s;
    logic                      force_high;
    logic                      force_low;
    logic                      trip_all;
    gdfc_pkg::gdfc_drive_e     state_r;
    logic [DCNT_W-1:0]         dcnt_r;
    logic                      high_raw_r;
    logic                      low_raw_r;
    logic [gdfc_pkg::BLANK_CNT_W-1:0] blank_r;
    logic [gdfc_pkg::BLANK_CNT_W-1:0] blank_len;
    logic [gdfc_pkg::BLANK_SEL_W-1:0] blank_sel;

    // Comparator levels are resynchronised before they touch any flag.
    gdfc_sync #(.STAGES(gdfc_pkg::SYNC_STAGES)) u_sync_vin (.clock(clock), .rst(rst),
        .async_in(input_uv_cmp), .sync_out(uv_in_s));
    gdfc_sync #(.STAGES(gdfc_pkg::SYNC_STAGES)) u_sync_uvo (.clock(clock), .rst(rst),
        .async_in(out_undervolt_cmp), .sync_out(uvo_s));
    gdfc_sync #(.STAGES(gdfc_pkg::SYNC_STAGES)) u_sync_ovo (.clock(clock), .rst(rst),
        .async_in(out_overvolt_cmp), .sync_out(ovo_s));
    gdfc_sync #(.STAGES(gdfc_pkg::SYNC_STAGES)) u_sync_oc (.clock(clock), .rst(rst),
        .async_in(overcurrent_cmp), .sync_out(oc_s));

    // Trip gates act while their flag is held.
    assign trip_all   = (undervolt_trip_gate & out_undervolt_flag)
                      | (overvolt_trip_gate & out_overvolt_flag);
    assign force_high = whole_driver_disable | high_side_disable | trip_all;
    assign force_low  = whole_driver_disable | low_side_disable | trip_all;

    // Dead-time sequencer: a side only rises after the other has been low for its delay, unless that side's delay bypass is set.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r    <= gdfc_pkg::GDFC_ST_BOTH_OFF;
            dcnt_r     <= '0;
            high_raw_r <= 1'b0;
            low_raw_r  <= 1'b0;
        end else begin
            unique case (state_r)
                gdfc_pkg::GDFC_ST_BOTH_OFF: begin
                    high_raw_r <= 1'b0;
                    low_raw_r  <= 1'b0;
                    if (pwm_in) begin
                        if (high_side_delay_bypass || dcnt_r >=
                            DCNT_W'(dead_time_setting_high) * DCNT_W'(DEAD_STEP_CYC)) begin
                            state_r    <= gdfc_pkg::GDFC_ST_HIGH_ON;
                            high_raw_r <= 1'b1;
                            dcnt_r     <= '0;
                        end else begin
                            dcnt_r <= dcnt_r + 1'b1;
                        end
                    end else begin
                        if (low_side_delay_bypass || dcnt_r >=
                            DCNT_W'(dead_time_setting_low) * DCNT_W'(DEAD_STEP_CYC)) begin
                            state_r   <= gdfc_pkg::GDFC_ST_LOW_ON;
                            low_raw_r <= 1'b1;
                            dcnt_r    <= '0;
                        end else begin
                            dcnt_r <= dcnt_r + 1'b1;
                        end
                    end
                end
                gdfc_pkg::GDFC_ST_HIGH_ON: begin
                    if (!pwm_in) begin
                        state_r    <= gdfc_pkg::GDFC_ST_BOTH_OFF;
                        high_raw_r <= 1'b0;
                        dcnt_r     <= '0;
                    end
                end
                gdfc_pkg::GDFC_ST_LOW_ON: begin
                    if (pwm_in) begin
                        state_r   <= gdfc_pkg::GDFC_ST_BOTH_OFF;
                        low_raw_r <= 1'b0;
                        dcnt_r    <= '0;
                    end
                end
                default: begin
                    state_r <= gdfc_pkg::GDFC_ST_BOTH_OFF;
                end
            endcase
        end
    end

    // Force-low gating is combinational so it takes effect in the same cycle.
    assign high_gate_drive = high_raw_r & ~force_high;
    assign low_gate_drive  = low_raw_r & ~force_low;

    // Blanking length grows with the select field.
    assign blank_sel = overcurrent_config[gdfc_pkg::BLANK_SEL_LSB +: gdfc_pkg::BLANK_SEL_W];
    assign blank_len = gdfc_pkg::BLANK_CNT_W'(blank_sel) * gdfc_pkg::BLANK_STEP_CYC;

    // Blanking counter restarts at each high-side turn-on.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            blank_r <= '0;
        end else if (!high_gate_drive) begin
            blank_r <= '0;
        end else if (blank_r < blank_len) begin
            blank_r <= blank_r + 1'b1;
        end
    end

    // Input undervoltage flag follows the comparator while input_uv_compare_enable is set; it is not sticky.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            input_uv_flag <= 1'b0;
        end else begin
            input_uv_flag <= input_uv_compare_enable & uv_in_s;
        end
    end

    // Output undervoltage flag is sticky; a new event beats the clear.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_undervolt_flag <= 1'b0;
        end else if (out_undervolt_compare_enable && uvo_s) begin
            out_undervolt_flag <= 1'b1;
        end else if (out_undervolt_flag_clear) begin
            out_undervolt_flag <= 1'b0;
        end
    end

    // Output overvoltage flag is sticky; a new event beats the clear.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_overvolt_flag <= 1'b0;
        end else if (out_overvolt_compare_enable && ovo_s) begin
            out_overvolt_flag <= 1'b1;
        end else if (out_overvolt_flag_clear) begin
            out_overvolt_flag <= 1'b0;
        end
    end

    // Overcurrent flag: only while high side conducts past blanking and compare enabled.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overcurrent_flag <= 1'b0;
        end else if (overcurrent_compare_enable && high_gate_drive
                     && blank_r >= blank_len && oc_s) begin
            overcurrent_flag <= 1'b1;
        end else if (overcurrent_flag_clear) begin
            overcurrent_flag <= 1'b0;
        end
    end

    // Output target is formed only from coarse and fine settings.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vout_target <= '0;
        end else begin
            vout_target <= {vout_coarse_set, vout_fine_set};
        end
    end

    // Assertions.
    property p_no_overlap;
        @(posedge clock) disable iff (rst) !(high_gate_drive && low_gate_drive);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both drives high");

    property p_drv_dis;
        @(posedge clock) disable iff (rst) whole_driver_disable |-> !high_gate_drive && !low_gate_drive;
    endproperty
    a_drv_dis: assert property (p_drv_dis) else $error("drive while disabled");

    property p_hi_dis;
        @(posedge clock) disable iff (rst) high_side_disable |-> !high_gate_drive;
    endproperty
    a_hi_dis: assert property (p_hi_dis) else $error("high drive while disabled");

    property p_lo_dis;
        @(posedge clock) disable iff (rst) low_side_disable |-> !low_gate_drive;
    endproperty
    a_lo_dis: assert property (p_lo_dis) else $error("low drive while disabled");

    property p_uv_trip;
        @(posedge clock) disable iff (rst)
            (undervolt_trip_gate && out_undervolt_flag) |-> !high_gate_drive && !low_gate_drive;
    endproperty
    a_uv_trip: assert property (p_uv_trip) else $error("drive during uv trip");

    property p_ov_trip;
        @(posedge clock) disable iff (rst)
            (overvolt_trip_gate && out_overvolt_flag) |-> !high_gate_drive && !low_gate_drive;
    endproperty
    a_ov_trip: assert property (p_ov_trip) else $error("drive during ov trip");

    property p_uv_sticky;
        @(posedge clock) disable iff (rst)
            out_undervolt_flag && !out_undervolt_flag_clear |=> out_undervolt_flag;
    endproperty
    a_uv_sticky: assert property (p_uv_sticky) else $error("uv flag lost");

    property p_ov_set;
        @(posedge clock) disable iff (rst)
            out_overvolt_compare_enable && ovo_s |=> out_overvolt_flag;
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("ov flag not set");

    property p_oc_en;
        @(posedge clock) disable iff (rst)
            !overcurrent_flag && !overcurrent_compare_enable |=> !overcurrent_flag;
    endproperty
    a_oc_en: assert property (p_oc_en) else $error("oc set while disabled");

    property p_vin_follow;
        @(posedge clock) disable iff (rst)
            input_uv_compare_enable && $stable(input_uv_compare_enable) && !uv_in_s |=> !input_uv_flag;
    endproperty
    a_vin_follow: assert property (p_vin_follow) else $error("vin flag not cleared");

    property p_vin_set;
        @(posedge clock) disable iff (rst)
            input_uv_compare_enable && uv_in_s |=> input_uv_flag;
    endproperty
    a_vin_set: assert property (p_vin_set) else $error("vin flag not set");

    property p_uv_set;
        @(posedge clock) disable iff (rst)
            out_undervolt_compare_enable && uvo_s |=> out_undervolt_flag;
    endproperty
    a_uv_set: assert property (p_uv_set) else $error("uv flag not set");

    property p_uv_en;
        @(posedge clock) disable iff (rst)
            !out_undervolt_flag && !out_undervolt_compare_enable |=> !out_undervolt_flag;
    endproperty
    a_uv_en: assert property (p_uv_en) else $error("uv set while disabled");

    property p_ov_en;
        @(posedge clock) disable iff (rst)
            !out_overvolt_flag && !out_overvolt_compare_enable |=> !out_overvolt_flag;
    endproperty
    a_ov_en: assert property (p_ov_en) else $error("ov set while disabled");

    property p_ov_sticky;
        @(posedge clock) disable iff (rst)
            out_overvolt_flag && !out_overvolt_flag_clear |=> out_overvolt_flag;
    endproperty
    a_ov_sticky: assert property (p_ov_sticky) else $error("ov flag lost");

    property p_oc_high;
        @(posedge clock) disable iff (rst)
            !overcurrent_flag && !high_gate_drive |=> !overcurrent_flag;
    endproperty
    a_oc_high: assert property (p_oc_high) else $error("oc set with high side off");

    property p_oc_blank;
        @(posedge clock) disable iff (rst)
            !overcurrent_flag && blank_r < blank_len |=> !overcurrent_flag;
    endproperty
    a_oc_blank: assert property (p_oc_blank) else $error("oc set inside blanking");

    property p_dead_hi;
        @(posedge clock) disable iff (rst)
            $rose(high_raw_r) |-> !low_raw_r && !$past(low_raw_r);
    endproperty
    a_dead_hi: assert property (p_dead_hi) else $error("high rose without dead gap");

    property p_dead_lo;
        @(posedge clock) disable iff (rst)
            $rose(low_raw_r) |-> !high_raw_r && !$past(high_raw_r);
    endproperty
    a_dead_lo: assert property (p_dead_lo) else $error("low rose without dead gap");

    property p_vout;
        @(posedge clock) disable iff (rst)
            !$past(rst) |-> vout_target == {$past(vout_coarse_set), $past(vout_fine_set)};
    endproperty
    a_vout: assert property (p_vout) else $error("target not from settings");

    c_high_on: cover property (@(posedge clock) disable iff (rst) $rose(high_gate_drive));
    c_low_on: cover property (@(posedge clock) disable iff (rst) $rose(low_gate_drive));
    c_oc_trip: cover property (@(posedge clock) disable iff (rst) $rose(overcurrent_flag));
    c_uv_trip: cover property (@(posedge clock) disable iff (rst) undervolt_trip_gate && $rose(out_undervolt_flag));
endmodule
`default_nettype wire

// *** sim/gdfc_fet_model.sv ***
// Behavioural model of the external high-side and low-side switches and their switch node.
// Assumes it sees the two gate drive outputs of the block on the core clock.
`timescale 1ns/1ps
`default_nettype none
module gdfc_fet_model (
    input  wire logic clock,
    input  wire logic high_gate_drive,
    input  wire logic low_gate_drive,
    output logic      switch_node,
    output logic      overlap_seen
);
    logic node_r    = 1'b0;
    logic overlap_r = 1'b0;

    // The node follows the conducting switch; with both off it floats, shown as a toggling level.
    always @(posedge clock) begin
        if (high_gate_drive === 1'b1 && low_gate_drive === 1'b1) begin
            overlap_r <= 1'b1;
        end
        if (high_gate_drive === 1'b1) begin
            node_r <= 1'b1;
        end else if (low_gate_drive === 1'b1) begin
            node_r <= 1'b0;
        end else begin
            node_r <= ~node_r;
        end
    end

    // Each output has a single driver.
    assign switch_node  = node_r;
    assign overlap_seen = overlap_r;
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the gate drive fault control block, random and corner stimulus.
// Assumes gdfc_top and the switch model; inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        pwm_in = 1'b0, high_side_delay_bypass = 1'b0, low_side_delay_bypass = 1'b0;
    logic [5:0]  dead_time_setting_high = 6'h00, dead_time_setting_low = 6'h00;
    logic        whole_driver_disable = 1'b0, high_side_disable = 1'b0, low_side_disable = 1'b0;
    logic        input_uv_compare_enable = 1'b0, input_uv_cmp = 1'b0;
    logic [7:0]  overcurrent_config = 8'h00;
    logic        overcurrent_compare_enable = 1'b0, overcurrent_cmp = 1'b0, overcurrent_flag_clear = 1'b0;
    logic [1:0]  en = 2'h0, cmp = 2'h0, gate = 2'h0, clr = 2'h0;
    logic [7:0]  vout_coarse_set = 8'h00, vout_fine_set = 8'h00;
    wire         high_gate_drive, low_gate_drive, input_uv_flag, overcurrent_flag, switch_node, overlap_seen;
    wire  [1:0]  fl;
    wire  [15:0] vout_target;
    int          n_fail = 0;
    int          num_checks = 0;

    gdfc_top i_gdfc_top (.clock, .rst, .pwm_in, .dead_time_setting_high, .dead_time_setting_low,
        .high_side_delay_bypass, .low_side_delay_bypass, .whole_driver_disable, .high_side_disable,
        .low_side_disable, .input_uv_compare_enable, .input_uv_cmp, .overcurrent_config,
        .overcurrent_compare_enable, .overcurrent_cmp, .out_undervolt_compare_enable(en[0]),
        .out_overvolt_compare_enable(en[1]), .out_undervolt_cmp(cmp[0]), .out_overvolt_cmp(cmp[1]),
        .undervolt_trip_gate(gate[0]), .overvolt_trip_gate(gate[1]), .out_undervolt_flag_clear(clr[0]),
        .out_overvolt_flag_clear(clr[1]), .overcurrent_flag_clear, .vout_coarse_set, .vout_fine_set,
        .high_gate_drive, .low_gate_drive, .input_uv_flag, .out_undervolt_flag(fl[0]),
        .out_overvolt_flag(fl[1]), .overcurrent_flag, .vout_target);
    gdfc_fet_model i_gdfc_fet_model (.clock, .high_gate_drive, .low_gate_drive, .switch_node, .overlap_seen);

    // Free-running 50 MHz core clock.
    always #10 clock = ~clock;

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic ck(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Counts falling edges until the chosen drive goes high, bounded so a stuck drive cannot hang.
    task automatic meas(input bit hi, output int m);
        m = 0;
        while (((hi ? high_gate_drive : low_gate_drive) !== 1'b1) && m < 200) begin
            cyc(1);
            m++;
        end
    endtask
    // True when a rise came inside the window that the dead-time code or the bypass allows.
    function automatic logic in_win(input int m, input int d, input bit byp);
        int lo;
        lo = byp ? 1 : d;
        return (m >= lo) && (m <= lo + 2);
    endfunction
    task automatic pulse_clr(input int k);
        clr[k] = 1'b1;
        cyc(1);
        clr[k] = 1'b0;
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Dead time on both sides with extreme and random codes, then with bypass.
    task automatic t_dead;
        int m, dh, dl;
        meas(1'b0, m);
        for (int i = 0; i < 8; i++) begin
            dh = (i == 1 || i == 6) ? 63 : (i == 0) ? 0 : $urandom % 64;
            dl = (i == 0 || i == 7) ? 63 : (i == 1) ? 0 : $urandom % 64;
            dead_time_setting_high = dh[5:0];
            dead_time_setting_low = dl[5:0];
            high_side_delay_bypass = (i > 5);
            low_side_delay_bypass = (i > 5);
            pwm_in = 1'b1;
            meas(1'b1, m);
            ck(in_win(m, dh, i > 5), 1'b1, "high rise wait");
            ck(low_gate_drive, 1'b0, "both high");
            pwm_in = 1'b0;
            meas(1'b0, m);
            ck(in_win(m, dl, i > 5), 1'b1, "low rise wait");
            ck(high_gate_drive, 1'b0, "both high");
        end
        $display("Test dead time done");
    endtask

    task automatic t_dis;
        pwm_in = 1'b1;
        cyc(4);
        whole_driver_disable = 1'b1;
        cyc(1);
        ck({high_gate_drive, low_gate_drive}, 2'b00, "whole disable");
        pwm_in = 1'b0;
        cyc(4);
        ck(low_gate_drive, 1'b0, "whole disable low");
        whole_driver_disable = 1'b0;
        cyc(4);
        ck(low_gate_drive, 1'b1, "restore");
        high_side_disable = 1'b1;
        pwm_in = 1'b1;
        cyc(4);
        ck(high_gate_drive, 1'b0, "high disabled");
        pwm_in = 1'b0;
        cyc(4);
        ck(low_gate_drive, 1'b1, "low still runs");
        high_side_disable = 1'b0;
        low_side_disable = 1'b1;
        cyc(1);
        ck(low_gate_drive, 1'b0, "low disabled");
        pwm_in = 1'b1;
        cyc(4);
        ck(high_gate_drive, 1'b1, "high still runs");
        ck(switch_node, 1'b1, "node follows high");
        low_side_disable = 1'b0;
        $display("Test disables done");
    endtask

    // Sticky output fault flags with and without their trip gates, high side running.
    task automatic t_fault(input int k);
        en[k] = 1'b0;
        cmp[k] = 1'b1;
        cyc(5);
        ck(fl[k], 1'b0, "flag while off");
        en[k] = 1'b1;
        gate[k] = 1'b1;
        cyc(4);
        ck(fl[k], 1'b1, "flag set");
        ck({high_gate_drive, low_gate_drive}, 2'b00, "trip low");
        cmp[k] = 1'b0;
        cyc(6);
        ck(fl[k], 1'b1, "flag sticky");
        ck(high_gate_drive, 1'b0, "trip hold");
        pulse_clr(k);
        cyc(4);
        ck(fl[k], 1'b0, "flag cleared");
        ck(high_gate_drive, 1'b1, "released");
        gate[k] = 1'b0;
        cmp[k] = 1'b1;
        cyc(4);
        ck({fl[k], high_gate_drive}, 2'b11, "no trip gate");
        cmp[k] = 1'b0;
        en[k] = 1'b0;
        pulse_clr(k);
        $display("Test fault %0d done", k);
    endtask

    // Overcurrent blanking for every select code, then with the compare disabled.
    task automatic t_oc;
        int m, n;
        for (int s = 0; s < 4; s++) begin
            overcurrent_config = {6'($urandom), 2'(s)};
            pwm_in = 1'b0;
            overcurrent_compare_enable = 1'b1;
            overcurrent_cmp = 1'b1;
            cyc(8);
            ck(overcurrent_flag, 1'b0, "oc with high off");
            pwm_in = 1'b1;
            meas(1'b1, m);
            n = 0;
            while (overcurrent_flag !== 1'b1 && n < 40) begin
                cyc(1);
                n++;
            end
            ck(n + 1 >= s * 5 && n <= s * 5 + 5, 1'b1, "blanking");
            overcurrent_cmp = 1'b0;
            pwm_in = 1'b0;
            // Let the synchroniser drain and the high side drop, else a new set beats the clear.
            cyc(3);
            overcurrent_flag_clear = 1'b1;
            cyc(1);
            overcurrent_flag_clear = 1'b0;
            ck(overcurrent_flag, 1'b0, "oc cleared");
        end
        overcurrent_compare_enable = 1'b0;
        overcurrent_cmp = 1'b1;
        pwm_in = 1'b1;
        cyc(30);
        ck(overcurrent_flag, 1'b0, "oc disabled");
        overcurrent_cmp = 1'b0;
        $display("Test overcurrent done");
    endtask

    initial begin
        void'($urandom(32'h20C6));
        cyc(12);
        ck({high_gate_drive, low_gate_drive, fl, overcurrent_flag, input_uv_flag}, 16'h0000, "reset");
        rst = 1'b0;
        t_dead();
        t_dis();
        input_uv_cmp = 1'b1;
        cyc(5);
        ck(input_uv_flag, 1'b0, "uv compare off");
        input_uv_compare_enable = 1'b1;
        cyc(4);
        ck(input_uv_flag, 1'b1, "input uv set");
        whole_driver_disable = 1'b1;
        input_uv_cmp = 1'b0;
        cyc(4);
        ck(input_uv_flag, 1'b0, "input uv self clear");
        whole_driver_disable = 1'b0;
        t_oc();
        t_fault(0);
        t_fault(1);
        repeat (4) begin
            vout_coarse_set = 8'($urandom);
            vout_fine_set = 8'($urandom);
            cyc(2);
            ck(vout_target, {vout_coarse_set, vout_fine_set}, "target");
        end
        ck(overlap_seen, 1'b0, "switch overlap");
        wrap_up();
    end

    // Watchdog well beyond the fewer than one thousand cycles the tests take.
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
